// ===== design/rx_queue_selector.v
// Receive queue selector for one port: filters, pools and RSS to queue.
// Assumes parsed packet fields arrive with a one-cycle valid strobe.
`include "rxq_defines.vh"
`default_nettype none

module rx_queue_selector (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        we_i,
  input  wire        re_i,
  output reg  [31:0] rdata_o,
  input  wire        pkt_valid_i,
  input  wire [15:0] ethertype_match_value_outer_i,
  input  wire [15:0] ethertype_match_value_inner_i,
  input  wire        ethertype_match_value_inner_vld_i,
  input  wire        l4_vld_i,
  input  wire        is_tcp_i,
  input  wire [7:0]  ip_proto_i,
  input  wire [15:0] dst_port_i,
  input  wire [13:0] pkt_len_i,
  input  wire [5:0]  tcp_flags_i,
  input  wire        syn_hit_i,
  input  wire [2:0]  syn_queue_i,
  input  wire        flex_hit_i,
  input  wire [2:0]  flex_queue_i,
  input  wire        flex_imm_i,
  input  wire [2:0]  rss_index_i,
  input  wire        tc_i,
  input  wire [2:0]  l2_pool_i,
  output reg         dec_valid_o,
  output reg  [3:0]  queue_o,
  output reg  [2:0]  pool_o,
  output reg         pool_redirect_o,
  output reg         mirror_o,
  output reg         timestamp_o,
  output reg         imm_irq_o,
  output reg  [2:0]  pkt_type_o,
  output reg         ethertype_match_value_hit_o
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg  [8:0]  ctrl_r;
  reg  [7:0]  mirror_r;
  reg  [8:0]  status_r;
  reg  [21:0] et_cfg_r  [0:7];
  reg  [13:0] ttq_cfg_r [0:7];
  reg  [17:0] immp_r    [0:7];
  reg  [21:0] imme_r    [0:7];
  reg  [31:0] qcfg_r    [0:7];

  wire [4:0]  grp = addr_i[7:3];
  wire [2:0]  idx = addr_i[2:0];
  wire [7:0]  et_hit;
  wire [7:0]  tt_hit;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : entry
      wire [21:0] et = et_cfg_r[g];
      wire [13:0] tq = ttq_cfg_r[g];
      wire [17:0] ip = immp_r[g];
      wire [21:0] ie = imme_r[g];
      wire        any_term;
      wire        t_proto;
      wire        t_port;
      wire        t_size;
      wire        t_flag;

      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          et_cfg_r[g]  <= `RST_CFG;
          ttq_cfg_r[g] <= 14'h0000;
          immp_r[g]    <= 18'h00000;
          imme_r[g]    <= `RST_CFG;
          qcfg_r[g]    <= `RST_WORD;
        end else if (we_i && idx == g) begin
          if (grp == `GRP_ETHERTYPE_MATCH_VALUE)
            et_cfg_r[g] <= wdata_i[21:0];
          if (grp == `GRP_TTQ)
            ttq_cfg_r[g] <= wdata_i[13:0];
          if (grp == `GRP_IMMP)
            immp_r[g] <= wdata_i[17:0];
          if (grp == `GRP_IMME)
            imme_r[g] <= wdata_i[21:0];
          if (grp == `GRP_QCFG)
            qcfg_r[g] <= wdata_i;
        end
      end

      // Ether-type compare against outer and inner type fields
      assign et_hit[g] = et[`ET_FEN] &
                         ((et[15:0] == ethertype_match_value_outer_i) |
                          (ethertype_match_value_inner_vld_i &
                           (et[15:0] == ethertype_match_value_inner_i)));

      assign t_proto  = tq[`TT_PMSK] |
                        (l4_vld_i & (tq[7:0] == ip_proto_i));
      assign t_port   = ip[`IP_BP] |
                        (l4_vld_i & (ip[15:0] == dst_port_i));
      assign t_size   = ie[`IE_SBP] | (pkt_len_i < ie[13:0]);
      assign t_flag   = ie[`IE_CBP] |
                        (is_tcp_i &
                         (|(ie[`IE_CLO+5:`IE_CLO] & tcp_flags_i)));
      assign any_term = ~tq[`TT_PMSK] | ~ip[`IP_BP] |
                        ~ie[`IE_SBP] | ~ie[`IE_CBP];
      assign tt_hit[g] = any_term & t_proto & t_port &
                         t_size & t_flag;
    end
  endgenerate

  // ****************************************************************
  // Control and read-only registers
  // ****************************************************************
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r   <= 9'h000;
      mirror_r <= 8'h00;
    end else if (we_i && grp == `GRP_MISC) begin
      if (idx == `IDX_CTRL)
        ctrl_r <= wdata_i[8:0];
      if (idx == `IDX_MIRROR)
        mirror_r <= wdata_i[7:0];
    end
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= `RST_WORD;
    end else if (re_i) begin
      case (grp)
        `GRP_MISC: begin
          case (idx)
            `IDX_CTRL:   rdata_o <= {23'h000000, ctrl_r};
            `IDX_STATUS: rdata_o <= {23'h000000, status_r};
            `IDX_MIRROR: rdata_o <= {24'h000000, mirror_r};
            default:     rdata_o <= `RST_WORD;
          endcase
        end
        `GRP_ETHERTYPE_MATCH_VALUE: rdata_o <= {10'h000, et_cfg_r[idx]};
        `GRP_TTQ:   rdata_o <= {18'h00000, ttq_cfg_r[idx]};
        `GRP_IMMP:  rdata_o <= {14'h0000, immp_r[idx]};
        `GRP_IMME:  rdata_o <= {10'h000, imme_r[idx]};
        `GRP_QCFG:  rdata_o <= qcfg_r[idx];
        default:    rdata_o <= `RST_WORD;
      endcase
    end else begin
      rdata_o <= `RST_WORD;
    end
  end

  // ****************************************************************
  // Lowest-index winners and OR-ed actions
  // ****************************************************************
  reg [2:0] et_idx;
  reg [2:0] tt_idx;
  reg       et_ts_any;
  reg       tt_ts_any;
  reg       tt_imm_any;
  integer   i;

  always @* begin
    et_idx     = 3'h0;
    tt_idx     = 3'h0;
    et_ts_any  = 1'b0;
    tt_ts_any  = 1'b0;
    tt_imm_any = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (et_hit[i])
        et_idx = i[2:0];
      if (tt_hit[i])
        tt_idx = i[2:0];
    end
    for (i = 0; i < 8; i = i + 1) begin
      et_ts_any  = et_ts_any | (et_hit[i] & et_cfg_r[i][`ET_TS]);
      tt_ts_any  = tt_ts_any | (tt_hit[i] & ttq_cfg_r[i][`TT_TS]);
      tt_imm_any = tt_imm_any | (tt_hit[i] & immp_r[i][`IP_IMM]);
    end
  end

  // ****************************************************************
  // Queue and pool decision
  // ****************************************************************
  wire [2:0] mode     = ctrl_r[2:0];
  wire [2:0] def_q    = ctrl_r[`CTRL_DEFQ_LO+2:`CTRL_DEFQ_LO];
  wire       syn_prio = ctrl_r[`CTRL_SYNPRIO];
  wire       tc_en    = ctrl_r[`CTRL_TCEN];
  wire       virt     = (mode == `MQ_VIRT) | (mode == `MQ_VIRT_RSS);
  wire       rss_on   = (mode == `MQ_FLT_RSS) & ctrl_r[`CTRL_RSSEN];
  wire       et_any   = |et_hit;
  wire [21:0] et_win  = et_cfg_r[et_idx];
  wire [13:0] tt_win  = ttq_cfg_r[tt_idx];
  wire       et_steer = et_any & et_win[`ET_QEN];
  wire       tt_steer = (|tt_hit) & tt_win[`TT_QEN];
  wire [2:0] et_q     = et_win[`ET_QLO+2:`ET_QLO];
  wire [2:0] tt_q     = tt_win[`TT_QLO+2:`TT_QLO];

  reg  [3:0] q_nxt;
  reg  [2:0] pool_nxt;
  reg        redir_nxt;

  always @* begin
    pool_nxt  = l2_pool_i;
    redir_nxt = 1'b0;
    if (virt) begin
      if (tc_en)
        q_nxt = {tc_i, l2_pool_i};
      else if (mode == `MQ_VIRT_RSS)
        q_nxt = {rss_index_i[0], l2_pool_i};
      else
        q_nxt = {1'b0, l2_pool_i};
    end else if (tc_en) begin
      q_nxt = rss_on ? {tc_i, rss_index_i} : {tc_i, 3'h0};
    end else if (rss_on) begin
      q_nxt = {1'b0, rss_index_i};
    end else begin
      q_nxt = {1'b0, def_q};
    end
    // Lowest priority override is applied first, highest last
    if (!virt && !syn_prio && syn_hit_i)
      q_nxt = {1'b0, syn_queue_i};
    if (!virt && tt_steer)
      q_nxt = {1'b0, tt_q};
    if (!virt && flex_hit_i)
      q_nxt = {1'b0, flex_queue_i};
    if (!virt && syn_prio && syn_hit_i)
      q_nxt = {1'b0, syn_queue_i};
    if (et_steer) begin
      q_nxt     = {1'b0, et_q};
      pool_nxt  = et_q;
      redir_nxt = virt;
    end
  end

  // ****************************************************************
  // Registered decision outputs
  // ****************************************************************
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dec_valid_o     <= 1'b0;
      queue_o         <= 4'h0;
      pool_o          <= 3'h0;
      pool_redirect_o <= 1'b0;
      mirror_o        <= 1'b0;
      timestamp_o     <= 1'b0;
      imm_irq_o       <= 1'b0;
      pkt_type_o      <= 3'h0;
      ethertype_match_value_hit_o     <= 1'b0;
      status_r        <= 9'h000;
    end else begin
      dec_valid_o <= pkt_valid_i;
      if (pkt_valid_i) begin
        queue_o         <= q_nxt;
        pool_o          <= pool_nxt;
        pool_redirect_o <= redir_nxt;
        mirror_o        <= virt & mirror_r[pool_nxt];
        timestamp_o     <= et_ts_any | (~virt & tt_ts_any);
        imm_irq_o       <= ~virt & (tt_imm_any |
                                    (flex_hit_i & flex_imm_i));
        pkt_type_o      <= et_idx;
        ethertype_match_value_hit_o     <= et_any;
        status_r        <= {1'b1, et_any, et_idx, q_nxt};
      end
    end
  end

endmodule // rx_queue_selector

`default_nettype wire

// ===== design/rxq_defines.vh
// Constants for the receive queue selector: register map, fields, modes.
// Assumes a word-addressed register port; one include per compile unit.
`ifndef RXQ_DEFINES_VH
`define RXQ_DEFINES_VH

// Address groups (addr[7:3]) and indices inside the misc group
`define GRP_MISC    5'h00
`define GRP_ETHERTYPE_MATCH_VALUE   5'h02
`define GRP_TTQ     5'h03
`define GRP_IMMP    5'h04
`define GRP_IMME    5'h05
`define GRP_QCFG    5'h06
`define IDX_CTRL    3'h0
`define IDX_STATUS  3'h1
`define IDX_MIRROR  3'h2

// Multi-queue mode codes
`define MQ_FILTER   3'h0
`define MQ_FLT_RSS  3'h2
`define MQ_VIRT     3'h3
`define MQ_VIRT_RSS 3'h5

// Control register fields
`define CTRL_DEFQ_LO  3
`define CTRL_SYNPRIO  6
`define CTRL_RSSEN    7
`define CTRL_TCEN     8

// Ether-type filter fields
`define ET_QLO   16
`define ET_TS    19
`define ET_QEN   20
`define ET_FEN   21
// Two-tuple queue fields
`define TT_QLO   8
`define TT_QEN   11
`define TT_PMSK  12
`define TT_TS    13
// Immediate port / extended fields
`define IP_BP    16
`define IP_IMM   17
`define IE_SBP   14
`define IE_CLO   15
`define IE_CBP   21

`define RST_WORD 32'h00000000
`define RST_CFG  22'h000000

`endif

// ===== tb/rx_dma_sink.sv
// Host receive queue side: latches each queue decision for the bench.
// Assumes decisions arrive as one-cycle strobes on the selector clock.
`default_nettype none
module rx_dma_sink (
  input  wire logic       clk_i,
  input  wire logic       dec_valid_i,
  input  wire logic [3:0] queue_i,
  input  wire logic [2:0] pool_i,
  input  wire logic [7:0] flags_i,
  output var  logic       seen_o,
  output var  logic [14:0] word_o
);
  initial seen_o = 1'b0;
  // Decision is taken in its only valid cycle, shown one cycle later
  always @(posedge clk_i) begin
    seen_o <= dec_valid_i;
    if (dec_valid_i) word_o <= {queue_i, pool_i, flags_i};
  end
endmodule // rx_dma_sink
`default_nettype wire

// ===== tb/rx_queue_selector_properties.sv
// Port checker for the receive queue selector.
// Assumes it is bound to the selector and sees only its ports.
`default_nettype none
module rx_queue_selector_properties (
  input wire        clk_i,
  input wire        sys_rst_i,
  input wire [7:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        we_i,
  input wire        re_i,
  input wire [31:0] rdata_o,
  input wire        pkt_valid_i,
  input wire        syn_hit_i,
  input wire [2:0]  syn_queue_i,
  input wire        flex_hit_i,
  input wire [2:0]  flex_queue_i,
  input wire [2:0]  l2_pool_i,
  input wire        dec_valid_o,
  input wire [3:0]  queue_o,
  input wire [2:0]  pool_o,
  input wire        pool_redirect_o,
  input wire        imm_irq_o,
  input wire [2:0]  pkt_type_o,
  input wire        ethertype_match_value_hit_o
);
  reg  [8:0] ctrl_r;
  wire       virt = ctrl_r[2:0] == 3'h3 || ctrl_r[2:0] == 3'h5;
  // Copy of the control word as last written
  always @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i) ctrl_r <= 9'h000;
    else if (we_i && addr_i == 8'h00) ctrl_r <= wdata_i[8:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  dec_pulse_a: assert property (pkt_valid_i |=> dec_valid_o)
    else $error("no decision after packet");
  dec_quiet_a: assert property (!pkt_valid_i |=> !dec_valid_o)
    else $error("decision without packet");
  rd_idle_a: assert property (!re_i |=> rdata_o == 32'h00000000)
    else $error("read data outside its slot");
  vm_queue_a: assert property (
    pkt_valid_i && ctrl_r[2:0] == 3'h3 && !ctrl_r[8]
    |=> ethertype_match_value_hit_o || queue_o == {1'b0, $past(l2_pool_i)})
    else $error("pool queue wrong");
  syn_first_a: assert property (
    pkt_valid_i && !virt && ctrl_r[6] && syn_hit_i
    |=> ethertype_match_value_hit_o || queue_o == {1'b0, $past(syn_queue_i)})
    else $error("syn filter lost priority");
  flex_first_a: assert property (
    pkt_valid_i && !virt && !ctrl_r[6] && flex_hit_i
    |=> ethertype_match_value_hit_o || queue_o == {1'b0, $past(flex_queue_i)})
    else $error("flex filter lost priority");
  type_none_a: assert property (
    dec_valid_o && !ethertype_match_value_hit_o |-> pkt_type_o == 3'h0)
    else $error("packet type without match");
  pool_redir_a: assert property (
    pool_redirect_o |-> ethertype_match_value_hit_o && queue_o == {1'b0, pool_o})
    else $error("redirect without steer");
  virt_imm_a: assert property (pkt_valid_i && virt |=> !imm_irq_o)
    else $error("immediate request in pool mode");
  cover property (pkt_valid_i && virt && flex_hit_i);
  cover property (dec_valid_o && pool_redirect_o);
  cover property (dec_valid_o && imm_irq_o);
endmodule // rx_queue_selector_properties

bind rx_queue_selector rx_queue_selector_properties i_props (
  .clk_i, .sys_rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o,
  .pkt_valid_i, .syn_hit_i, .syn_queue_i, .flex_hit_i, .flex_queue_i,
  .l2_pool_i, .dec_valid_o, .queue_o, .pool_o, .pool_redirect_o,
  .imm_irq_o, .pkt_type_o, .ethertype_match_value_hit_o);
`default_nettype wire

// ===== tb/rx_queue_selector_test.sv
// Self-checking bench for the receive queue selector.
// Assumes the selector and the host side sink are compiled alongside.
`default_nettype none
module rx_queue_selector_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0;
  logic        pkt_valid_i = 1'b0, ethertype_match_value_inner_vld_i = 1'b0, l4_vld_i = 1'b0;
  logic        is_tcp_i = 1'b0, syn_hit_i = 1'b0, flex_hit_i = 1'b0;
  logic        flex_imm_i = 1'b0, tc_i = 1'b0, seen;
  logic [7:0]  addr_i = 8'h00, ip_proto_i = 8'h00, mmask;
  logic [31:0] wdata_i = 32'h00000000, rdata_o, d, g32;
  logic [15:0] ethertype_match_value_outer_i = 16'h0000, ethertype_match_value_inner_i = 16'h0000;
  logic [15:0] dst_port_i = 16'h0000, e, g;
  logic [13:0] pkt_len_i = 14'h0000;
  logic [5:0]  tcp_flags_i = 6'h00;
  logic [2:0]  syn_queue_i = 3'h0, flex_queue_i = 3'h0, rss_index_i = 3'h0;
  logic [2:0]  l2_pool_i = 3'h0, pool_o, pkt_type_o, mode, defq;
  logic [3:0]  queue_o;
  logic        dec_valid_o, pool_redirect_o, mirror_o, timestamp_o;
  logic        imm_irq_o, ethertype_match_value_hit_o, sp, rsen, tcen;
  logic [14:0] word;
  logic [15:0] exp_q [$];
  int          bad_count = 0, n_tests = 0;
  logic [15:0] ets [4] = '{16'h0800, 16'h88F7, 16'h88CC, 16'h86DD};
  logic [2:0]  modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h2};
  // Filters: disabled, steering, non-steering; 2-tuple by proto, size, none
  logic [39:0] cfg [12] = '{40'h1000190800, 40'h12003D88F7, 40'h13002488CC,
    40'h1800002E11, 40'h1900001A00, 40'h1A00001F00, 40'h2000010000,
    40'h2100030000, 40'h2200010000, 40'h2800204000, 40'h2900200040,
    40'h2A00204000};

  rx_queue_selector i_rx_queue_selector (.clk_i, .sys_rst_i, .addr_i,
    .wdata_i, .we_i, .re_i, .rdata_o, .pkt_valid_i, .ethertype_match_value_outer_i,
    .ethertype_match_value_inner_i, .ethertype_match_value_inner_vld_i, .l4_vld_i, .is_tcp_i, .ip_proto_i,
    .dst_port_i, .pkt_len_i, .tcp_flags_i, .syn_hit_i, .syn_queue_i,
    .flex_hit_i, .flex_queue_i, .flex_imm_i, .rss_index_i, .tc_i,
    .l2_pool_i, .dec_valid_o, .queue_o, .pool_o, .pool_redirect_o,
    .mirror_o, .timestamp_o, .imm_irq_o, .pkt_type_o, .ethertype_match_value_hit_o);
  rx_dma_sink i_rx_dma_sink (.clk_i, .dec_valid_i(dec_valid_o),
    .queue_i(queue_o), .pool_i(pool_o), .flags_i({pool_redirect_o,
    mirror_o, timestamp_o, imm_irq_o, pkt_type_o, ethertype_match_value_hit_o}),
    .seen_o(seen), .word_o(word));

  always #10 clk_i = ~clk_i;

  // ******************************
  // Bus cycles, model and checks
  // ******************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= dat;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 dat = rdata_o;
  endtask
  task automatic send();
    logic [15:0] o, i;
    logic [13:0] ln;
    logic [7:0]  pr;
    logic [3:0]  q;
    logic [2:0]  sq, fq, pl, r, p, ty;
    logic        iv, l4, sh, fh, fi, tc, v, rs, e2, e3, t0, t1;
    o = ets[$urandom % 4];
    i = ets[$urandom % 4];
    {iv, l4, sh, fh, fi, tc, sq, fq, pl} = 15'($urandom);
    ln = 14'($urandom % 128);
    pr = ($urandom % 2) ? 8'h11 : 8'h06;
    v = mode == 3'h3 || mode == 3'h5;
    rs = (mode == 3'h2 && rsen) || mode == 3'h5;
    r = rs ? 3'($urandom) : 3'h0;
    e2 = o == 16'h88F7 || (iv && i == 16'h88F7);
    e3 = o == 16'h88CC || (iv && i == 16'h88CC);
    t0 = !v && l4 && pr == 8'h11;
    t1 = !v && ln < 14'h0040;
    if (tcen) q = v ? {tc, pl} : {tc, r};
    else if (v) q = {mode == 3'h5 && r[0], pl};
    else q = {1'b0, rs ? r : defq};
    if (e2) q = 4'h5;
    else if (!v && sh && (sp || !(fh || t0 || t1))) q = {1'b0, sq};
    else if (!v && fh) q = {1'b0, fq};
    else if (t0 || t1) q = t0 ? 4'h6 : 4'h2;
    p = e2 ? 3'h5 : pl;
    ty = e2 ? 3'h2 : e3 ? 3'h3 : 3'h0;
    exp_q.push_back({v, q, v ? p : 3'h0, v && e2, v && mmask[p], e2 || t0,
      t1 || (!v && fh && fi), ty, e2 || e3});
    @(posedge clk_i);
    {pkt_valid_i, ethertype_match_value_outer_i, ethertype_match_value_inner_i, ethertype_match_value_inner_vld_i, l4_vld_i,
      ip_proto_i, pkt_len_i, syn_hit_i, syn_queue_i, flex_hit_i,
      flex_queue_i, flex_imm_i, rss_index_i, tc_i, l2_pool_i} <= {1'b1, o,
      i, iv, l4, pr, ln, sh, sq, fh, fq, fi, r, tc, pl};
    {is_tcp_i, tcp_flags_i, dst_port_i} <= 23'($urandom);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i)
    if (seen) begin
      e = exp_q.pop_front();
      g = {1'b0, word[14:11], e[15] ? word[10:8] : 3'h0, word[7:0]};
      check(g[14:11], e[14:11]);
      check(g[10:6], e[10:6]);
      check(g[5:0], e[5:0]);
    end

  initial begin
    void'($urandom(32));
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    foreach (cfg[k]) wr(cfg[k][39:32], cfg[k][31:0]);
    for (int k = 0; k < 8; k++) begin
      d = $urandom;
      wr(8'h30 + 8'(k), d);
      rd(8'h30 + 8'(k), g32);
      check(g32, d);
    end
    rd(8'h7F, g32);
    check(g32, 32'h00000000);
    for (int k = 0; k < 200; k++) begin
      mode = modes[$urandom % 6];
      {tcen, rsen, sp, defq, mmask} = 14'($urandom);
      wr(8'h00, {23'h000000, tcen, rsen, sp, defq, mode});
      wr(8'h02, {24'h000000, mmask});
      repeat (3) send();
      @(posedge clk_i);
      pkt_valid_i <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    check(exp_q.size(), 0);
    report_and_stop();
  end

  initial begin
    #200_000;
    bad_count++;
    report_and_stop();
  end
endmodule // rx_queue_selector_test
`default_nettype wire
